// File: logic/tvd_defines.svh
// Register offsets, field positions, reset values and delegation masks
`ifndef TVD_DEFINES_SVH
`define TVD_DEFINES_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define TVD_OFF_TVEC      8'h00
`define TVD_OFF_EDELEG    8'h04
`define TVD_OFF_IDELEG    8'h08
`define TVD_OFF_SEDELEG   8'h0C
`define TVD_OFF_SIDELEG   8'h10
`define TVD_OFF_STVEC     8'h14
`define TVD_OFF_UTVEC     8'h18
`define TVD_OFF_SCAUSE    8'h1C
`define TVD_OFF_SEPC      8'h20
`define TVD_OFF_UCAUSE    8'h24
`define TVD_OFF_UEPC      8'h28
`define TVD_OFF_STATUS    8'h2C
`define TVD_OFF_MCAUSE    8'h30
`define TVD_OFF_MEPC      8'h34

// ---------------------------------------------------------------
// Fields
// ---------------------------------------------------------------
`define TVD_MODE_LSB      0
`define TVD_MODE_MSB      1
`define TVD_BASE_LSB      2
`define TVD_MODE_DIRECT   2'h0
`define TVD_MODE_VECTORED 2'h1
`define TVD_CAUSE_INT_BIT 31
// Status layout: user ie 0, sup ie 1, mach ie 3, user pie 4,
// sup pie 5, mach pie 7, sup pp 8, mach pp 12:11
`define TVD_ST_UIE        0
`define TVD_ST_SIE        1
`define TVD_ST_MIE        3
`define TVD_ST_UPIE       4
`define TVD_ST_SPIE       5
`define TVD_ST_MACHINE_PREVIOUS_INT_ENABLE       7
`define TVD_ST_SPP        8
`define TVD_ST_MPP_LSB    11

// ---------------------------------------------------------------
// Reset values and delegatable positions
// ---------------------------------------------------------------
`define TVD_TVEC_RESET    32'h0000_0000
`define TVD_EDELEG_MASK   32'h0000_B3FF
`define TVD_SEDELEG_MASK  32'h0000_B1FF
`define TVD_IDELEG_MASK   32'h0000_0333
`define TVD_SIDELEG_MASK  32'h0000_0111
`define TVD_STATUS_RESET  32'h0000_1800

`endif

// File: logic/tvd_pkg.sv
// Types shared by the trap vector and delegation block
package tvd_pkg;

  typedef enum logic [1:0] {
    TVD_PRIV_U = 2'h0,
    TVD_PRIV_S = 2'h1,
    TVD_PRIV_M = 2'h3
  } tvd_priv_t;

  typedef enum logic [1:0] {
    TVD_SYS_M,
    TVD_SYS_MU,
    TVD_SYS_MUN,
    TVD_SYS_MSU
  } tvd_sys_t;

endpackage

// File: logic/tvd_trap_unit.sv
// Trap target selection, delegation and trap state update
//
// How it works
// (RULE1) Vector register: word base in upper bits, two-bit mode in bits 1:0.
// (RULE2) Vector register always present; optionally hardwired or restricted.
// (RULE3) Vector base always four-byte aligned; low bits never stored.
// (RULE4) Mode 0 is direct, mode 1 is vectored, two and above reserved.
// (RULE5) Direct mode sends every machine trap to the base address.
// (RULE6) Vectored: exceptions to base, interrupts to base plus four times cause.
// (RULE7) Vectored mode may force stricter base alignment, up to 4*width bytes.
// (RULE8) Vectored interrupt cause zero lands at the exception address.
// (RULE9) Without delegation every trap is handled in machine mode.
// (RULE10) With supervisor, machine delegation bits send S/U traps to supervisor.
// (RULE11) Supervisor delegation bits pass user-mode traps on to user handler.
// (RULE12) Machine-user system with user traps: delegation sends to user handler.
// (RULE13) Without delegation targets both machine delegation registers are absent.
// (RULE14) Delegated trap writes target cause, pc, prior mode, prior ie; clears ie.
// (RULE15) Delegated trap leaves machine cause, pc, prior mode and ie untouched.
// (RULE16) No delegation bit stuck at one; all-ones readback shows supported bits.
// (RULE17) Traps never go to a less privileged mode than the current one.
// (RULE18) Delegated trap raised in its target mode stays in that mode.
// (RULE19) Exception delegation bit index equals cause; bit 8 is user ecall.
// (RULE20) Interrupt delegation follows pending layout; supervisor timer in bit 5.
// (RULE21) Impossible exceptions read zero: machine bit 11, supervisor bits 11:9.
// (RULE22) A reserved mode write leaves the mode field at a legal value.
`timescale 1ns/1ps
`include "tvd_defines.svh"

module tvd_trap_unit #(
  parameter tvd_pkg::tvd_sys_t SYS         = tvd_pkg::TVD_SYS_MSU,
  parameter bit                TVEC_RO     = 1'b0,
  parameter logic [31:0]       TVEC_FIXED  = `TVD_TVEC_RESET,
  parameter int                VEC_ALIGN   = 2
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // Trap request from the pipeline
  input  wire logic        trap_valid,
  input  wire logic        trap_is_int,
  input  wire logic [4:0]  trap_cause,
  input  wire logic [31:0] trap_pc,
  input  wire logic [1:0]  cur_priv,
  // Trap answer
  output logic             trap_taken,
  output logic      [31:0] trap_target_pc,
  output logic      [1:0]  trap_new_priv,
  output logic      [31:0] status_o
);

  // -------------------------------------------------------------
  // Elaboration checks
  // -------------------------------------------------------------
  // Alignment in vectored mode up to 4*32 bytes, i.e. 7 low bits
  if (VEC_ALIGN < 2 || VEC_ALIGN > 7) begin : g_bad_align
    $error("VEC_ALIGN must lie in 2..7");
  end

  localparam bit HAS_S   = (SYS == tvd_pkg::TVD_SYS_MSU);
  localparam bit HAS_N   = (SYS == tvd_pkg::TVD_SYS_MUN) || HAS_S;
  localparam bit HAS_DEL = HAS_S || (SYS == tvd_pkg::TVD_SYS_MUN);  // [RULE13]
  localparam logic [31:0] EMASK  = HAS_DEL ? `TVD_EDELEG_MASK : 32'h0000_0000;
  localparam logic [31:0] IMASK  = HAS_DEL ? `TVD_IDELEG_MASK : 32'h0000_0000;
  localparam logic [31:0] SEMASK = (HAS_S && HAS_N) ? `TVD_SEDELEG_MASK : 32'h0000_0000;
  localparam logic [31:0] SIMASK = (HAS_S && HAS_N) ? `TVD_SIDELEG_MASK : 32'h0000_0000;

  // -------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------
  logic [31:0] tvec_q, edeleg_q, ideleg_q, sedeleg_q, sideleg_q;
  logic [31:0] stvec_q, utvec_q, scause_q, sepc_q, ucause_q, uepc_q;
  logic [31:0] mcause_q, mepc_q, status_q;
  logic        ack_q;

  // -------------------------------------------------------------
  // Bus decode
  // -------------------------------------------------------------
  wire req      = wb_cyc_i && wb_stb_i && !ack_q;
  wire hit_tvec = (wb_adr_i == `TVD_OFF_TVEC);
  wire hit_ed   = (wb_adr_i == `TVD_OFF_EDELEG) && HAS_DEL;
  wire hit_id   = (wb_adr_i == `TVD_OFF_IDELEG) && HAS_DEL;
  wire hit_sed  = (wb_adr_i == `TVD_OFF_SEDELEG) && HAS_S && HAS_N;
  wire hit_sid  = (wb_adr_i == `TVD_OFF_SIDELEG) && HAS_S && HAS_N;
  wire hit_stv  = (wb_adr_i == `TVD_OFF_STVEC) && HAS_S;
  wire hit_utv  = (wb_adr_i == `TVD_OFF_UTVEC) && HAS_N;
  wire hit_sc   = (wb_adr_i == `TVD_OFF_SCAUSE) && HAS_S;
  wire hit_se   = (wb_adr_i == `TVD_OFF_SEPC) && HAS_S;
  wire hit_uc   = (wb_adr_i == `TVD_OFF_UCAUSE) && HAS_N;
  wire hit_ue   = (wb_adr_i == `TVD_OFF_UEPC) && HAS_N;
  wire hit_st   = (wb_adr_i == `TVD_OFF_STATUS);
  wire hit_mc   = (wb_adr_i == `TVD_OFF_MCAUSE);
  wire hit_me   = (wb_adr_i == `TVD_OFF_MEPC);
  wire hit_any  = hit_tvec | hit_ed | hit_id | hit_sed | hit_sid | hit_stv | hit_utv |
                  hit_sc | hit_se | hit_uc | hit_ue | hit_st | hit_mc | hit_me;
  // Req is masked by ack_q on the ack edge, so the write strobe qualifies on cyc and stb alone
  wire wr       = wb_cyc_i && wb_stb_i && wb_we_i && hit_any;

  // Byte-lane merge of write data into an old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Legalise a vector word: reserved mode keeps the old mode, base is aligned
  function automatic logic [31:0] legal_vec(input logic [31:0] nw, input logic [31:0] old);
    logic [1:0]  m;
    logic [31:0] b;
    m = (nw[1:0] >= 2'h2) ? old[1:0] : nw[1:0];  // [RULE22] [RULE4]
    b = {nw[31:2], 2'h0};  // [RULE3] [RULE1]
    if (m == `TVD_MODE_VECTORED) begin
      b = b & ~((32'h1 << VEC_ALIGN) - 32'h1);  // [RULE7]
    end
    return {b[31:2], m};
  endfunction

  wire [31:0] wmerge = merge(wb_dat_o, wb_dat_i, wb_sel_i);

  assign wb_ack_o = ack_q && wb_cyc_i && wb_stb_i;
  assign wb_err_o = 1'b0;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_q    <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_q    <= req;
      // Unmapped offsets answer with zero data
      wb_dat_o <= hit_tvec ? tvec_q : hit_ed ? edeleg_q : hit_id ? ideleg_q :
                  hit_sed ? sedeleg_q : hit_sid ? sideleg_q : hit_stv ? stvec_q :
                  hit_utv ? utvec_q : hit_sc ? scause_q : hit_se ? sepc_q :
                  hit_uc ? ucause_q : hit_ue ? uepc_q : hit_st ? status_q :
                  hit_mc ? mcause_q : hit_me ? mepc_q : 32'h0000_0000;
    end
  end

  // Write happens at the edge that the ack is sampled, once per access
  wire we_now = wr && ack_q;

  // -------------------------------------------------------------
  // Target privilege selection
  // -------------------------------------------------------------
  wire        m_del   = trap_is_int ? ideleg_q[trap_cause] : edeleg_q[trap_cause];   // [RULE19] [RULE20]
  wire        s_del   = trap_is_int ? sideleg_q[trap_cause] : sedeleg_q[trap_cause];
  wire        cur_m   = (cur_priv == tvd_pkg::TVD_PRIV_M);
  wire        cur_u   = (cur_priv == tvd_pkg::TVD_PRIV_U);
  logic [1:0] tgt;
  always_comb begin
    tgt = tvd_pkg::TVD_PRIV_M;  // [RULE9]
    if (!cur_m && m_del && HAS_S) begin
      tgt = (cur_u && s_del && HAS_N) ? tvd_pkg::TVD_PRIV_U
                                      : tvd_pkg::TVD_PRIV_S;  // [RULE10] [RULE11] [RULE18]
    end else if (!cur_m && m_del && HAS_N) begin
      tgt = tvd_pkg::TVD_PRIV_U;  // [RULE12]
    end
    // A machine-mode trap falls to the default branch: never downward [RULE17]
  end

  wire [31:0] vec_sel = (tgt == tvd_pkg::TVD_PRIV_M) ? tvec_q :
                        (tgt == tvd_pkg::TVD_PRIV_S) ? stvec_q : utvec_q;
  wire [31:0] vbase   = {vec_sel[31:2], 2'h0};
  // Cause zero lands on the base, which also serves exceptions [RULE8]
  wire [31:0] vtgt    = (trap_is_int && vec_sel[1:0] == `TVD_MODE_VECTORED)
                      ? vbase + {25'h0, trap_cause, 2'h0} : vbase;  // [RULE5] [RULE6]
  wire [31:0] cause_w = {trap_is_int, 26'h0, trap_cause};
  wire [31:0] epc_w   = {trap_pc[31:2], 2'h0};

  // -------------------------------------------------------------
  // Trap answer
  // -------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trap_taken     <= 1'b0;
      trap_target_pc <= 32'h0000_0000;
      trap_new_priv  <= tvd_pkg::TVD_PRIV_M;
    end else begin
      trap_taken <= trap_valid;
      if (trap_valid) begin
        trap_target_pc <= vtgt;
        trap_new_priv  <= tgt;
      end
    end
  end

  // -------------------------------------------------------------
  // Vector and delegation registers
  // -------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tvec_q    <= TVEC_FIXED;
      edeleg_q  <= 32'h0000_0000;
      ideleg_q  <= 32'h0000_0000;
      sedeleg_q <= 32'h0000_0000;
      sideleg_q <= 32'h0000_0000;
      stvec_q   <= `TVD_TVEC_RESET;
      utvec_q   <= `TVD_TVEC_RESET;
    end else if (we_now) begin
      if (hit_tvec && !TVEC_RO) begin
        tvec_q <= legal_vec(wmerge, tvec_q);  // [RULE2]
      end
      if (hit_ed) begin
        edeleg_q <= wmerge & EMASK;  // [RULE16] [RULE21]
      end
      if (hit_id) begin
        ideleg_q <= wmerge & IMASK;  // [RULE16]
      end
      if (hit_sed) begin
        sedeleg_q <= wmerge & SEMASK;  // [RULE21]
      end
      if (hit_sid) begin
        sideleg_q <= wmerge & SIMASK;
      end
      if (hit_stv) begin
        stvec_q <= legal_vec(wmerge, stvec_q);
      end
      if (hit_utv) begin
        utvec_q <= legal_vec(wmerge, utvec_q);
      end
    end
  end

  // -------------------------------------------------------------
  // Cause, exception pc and status; trap update beats a bus write
  // -------------------------------------------------------------
  wire to_m = trap_valid && tgt == tvd_pkg::TVD_PRIV_M;
  wire to_s = trap_valid && tgt == tvd_pkg::TVD_PRIV_S;
  wire to_u = trap_valid && tgt == tvd_pkg::TVD_PRIV_U;
  // Saved enable is that of the mode running when the trap hits
  wire cur_ie = cur_m ? status_q[`TVD_ST_MIE] :
                cur_u ? status_q[`TVD_ST_UIE] : status_q[`TVD_ST_SIE];

  logic [31:0] status_d;
  always_comb begin
    status_d = status_q;
    if (to_m) begin
      status_d[`TVD_ST_MACHINE_PREVIOUS_INT_ENABLE] = cur_ie;
      status_d[`TVD_ST_MIE]  = 1'b0;
      status_d[`TVD_ST_MPP_LSB +: 2] = cur_priv;
    end else if (to_s) begin
      status_d[`TVD_ST_SPIE] = cur_ie;  // [RULE14] [RULE15]
      status_d[`TVD_ST_SIE]  = 1'b0;
      status_d[`TVD_ST_SPP]  = cur_priv[0];
    end else if (to_u) begin
      status_d[`TVD_ST_UPIE] = cur_ie;  // [RULE14]
      status_d[`TVD_ST_UIE]  = 1'b0;
    end else if (we_now && hit_st) begin
      status_d = wmerge;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_q <= `TVD_STATUS_RESET;
      mcause_q <= 32'h0000_0000;
      mepc_q   <= 32'h0000_0000;
      scause_q <= 32'h0000_0000;
      sepc_q   <= 32'h0000_0000;
      ucause_q <= 32'h0000_0000;
      uepc_q   <= 32'h0000_0000;
    end else begin
      status_q <= status_d;
      if (to_m) begin
        mcause_q <= cause_w;
        mepc_q   <= epc_w;
      end else if (we_now && hit_mc) begin
        mcause_q <= wmerge;
      end else if (we_now && hit_me) begin
        mepc_q <= {wmerge[31:2], 2'h0};
      end
      if (to_s) begin
        scause_q <= cause_w;  // [RULE14]
        sepc_q   <= epc_w;
      end else if (we_now && hit_sc) begin
        scause_q <= wmerge;
      end else if (we_now && hit_se) begin
        sepc_q <= {wmerge[31:2], 2'h0};
      end
      if (to_u) begin
        ucause_q <= cause_w;
        uepc_q   <= epc_w;
      end else if (we_now && hit_uc) begin
        ucause_q <= wmerge;
      end else if (we_now && hit_ue) begin
        uepc_q <= {wmerge[31:2], 2'h0};
      end
    end
  end

  assign status_o = status_q;

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  chk_mode_legal: assert property (@(posedge sys_clk) disable iff (rst)
    tvec_q[1:0] < 2'h2) else $error("vector mode holds reserved value");  // [RULE22]

  chk_no_downward: assert property (@(posedge sys_clk) disable iff (rst)
    trap_valid && cur_m |=> trap_new_priv == tvd_pkg::TVD_PRIV_M)
    else $error("machine trap left machine mode");  // [RULE17]

  chk_direct_base: assert property (@(posedge sys_clk) disable iff (rst)
    trap_valid && tgt == tvd_pkg::TVD_PRIV_M && tvec_q[1:0] == `TVD_MODE_DIRECT
    |=> trap_target_pc == $past(vbase)) else $error("direct trap off base");  // [RULE5]

  chk_vector_int: assert property (@(posedge sys_clk) disable iff (rst)
    trap_valid && trap_is_int && tgt == tvd_pkg::TVD_PRIV_M &&
    tvec_q[1:0] == `TVD_MODE_VECTORED
    |=> trap_target_pc == $past({tvec_q[31:2], 2'h0}) + {25'h0, $past(trap_cause), 2'h0})
    else $error("vectored interrupt target wrong");  // [RULE6]

  chk_mcause_keep: assert property (@(posedge sys_clk) disable iff (rst)
    to_s || to_u |=> $stable(mcause_q) && $stable(mepc_q))
    else $error("delegated trap touched machine cause");  // [RULE15]

  chk_del_ie_clear: assert property (@(posedge sys_clk) disable iff (rst)
    to_s |=> !status_q[`TVD_ST_SIE] && scause_q == $past(cause_w))
    else $error("supervisor trap state not updated");  // [RULE14]

  chk_bit11_zero: assert property (@(posedge sys_clk) disable iff (rst)
    !edeleg_q[11] && sedeleg_q[11:9] == 3'h0) else $error("fixed-zero bit set");  // [RULE21]

  chk_undelegated_m: assert property (@(posedge sys_clk) disable iff (rst)
    trap_valid && !m_del |=> trap_new_priv == tvd_pkg::TVD_PRIV_M)
    else $error("undelegated trap left machine");  // [RULE9]

  chk_ack_once: assert property (@(posedge sys_clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");

  chk_vec_cause0: assert property (@(posedge sys_clk) disable iff (rst)
    trap_valid && trap_is_int && trap_cause == 5'h00 |=> trap_target_pc == $past(vbase))
    else $error("cause zero interrupt off base");  // [RULE8]

  chk_vec_exception: assert property (@(posedge sys_clk) disable iff (rst)
    trap_valid && !trap_is_int |=> trap_target_pc == $past(vbase))
    else $error("exception not sent to base");  // [RULE6]

  chk_stay_horizontal: assert property (@(posedge sys_clk) disable iff (rst)
    trap_valid && cur_priv == tvd_pkg::TVD_PRIV_S && m_del && HAS_S
    |=> trap_new_priv == tvd_pkg::TVD_PRIV_S)
    else $error("supervisor trap left its mode");  // [RULE18]

  chk_user_route: assert property (@(posedge sys_clk) disable iff (rst)
    trap_valid && cur_u && m_del && s_del && HAS_S && HAS_N
    |=> trap_new_priv == tvd_pkg::TVD_PRIV_U)
    else $error("user trap not passed on");  // [RULE11]

  chk_user_state: assert property (@(posedge sys_clk) disable iff (rst)
    to_u |=> !status_q[`TVD_ST_UIE] && ucause_q == $past(cause_w) &&
    uepc_q == $past(epc_w))
    else $error("user trap state not updated");  // [RULE14]

  chk_taken_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    trap_taken == $past(trap_valid)) else $error("trap answer not one cycle late");

  chk_sub_mode_legal: assert property (@(posedge sys_clk) disable iff (rst)
    stvec_q[1:0] < 2'h2 && utvec_q[1:0] < 2'h2) else $error("sub vector mode reserved");  // [RULE22]

  chk_deleg_write: assert property (@(posedge sys_clk) disable iff (rst)
    wb_ack_o && wb_we_i && hit_ed |=> edeleg_q == ($past(wmerge) & EMASK))
    else $error("delegation write lost");  // [RULE16]

endmodule

// File: bench/tvd_core_model.sv
// Behavioural pipeline model that raises trap requests
`timescale 1ns/1ps

module tvd_core_model (
  input  wire logic        sys_clk,
  output logic             trap_valid,
  output logic             trap_is_int,
  output logic      [4:0]  trap_cause,
  output logic      [31:0] trap_pc,
  output logic      [1:0]  cur_priv
);
  initial begin
    trap_valid  = 1'b0;
    trap_is_int = 1'b0;
    trap_cause  = 5'h00;
    trap_pc     = 32'h0000_0000;
    cur_priv    = 2'h3;
  end

  // ---------------------------------------------------------------
  // One-cycle trap request
  // ---------------------------------------------------------------
  // Cause, type and pc are inverted once valid drops (cur_priv is held), so a unit that samples
  // them outside the request edge sees garbage rather than a copy
  task automatic raise(input logic is_int, input logic [4:0] cause,
                       input logic [31:0] pc, input logic [1:0] priv);
    @(posedge sys_clk);
    trap_valid  <= 1'b1;
    trap_is_int <= is_int;
    trap_cause  <= cause;
    trap_pc     <= pc;
    cur_priv    <= priv;
    @(posedge sys_clk);
    trap_valid  <= 1'b0;
    trap_is_int <= ~is_int;
    trap_cause  <= ~cause;
    trap_pc     <= ~pc;
  endtask
endmodule

// File: bench/trap_vector_and_delegation_tb_top.sv
// Self-checking bench for the trap vector and delegation unit
`timescale 1ns/1ps
`include "tvd_defines.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module trap_vector_and_delegation_tb_top;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o, trap_pc, trap_target_pc, status_o;
  logic        wb_ack_o, wb_err_o, trap_valid, trap_is_int, trap_taken;
  logic [4:0]  trap_cause;
  logic [1:0]  cur_priv, trap_new_priv, priv_un;
  int          errors = 0;
  int          checks = 0;
  int          cycles = 0;
  logic [31:0] dv [4];
  logic [31:0] vec [4];
  logic [31:0] st_e, mc_e, me_e, rd, dat_mu, rd_mu;

  tvd_trap_unit dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .trap_valid(trap_valid),
    .trap_is_int(trap_is_int), .trap_cause(trap_cause), .trap_pc(trap_pc),
    .cur_priv(cur_priv), .trap_taken(trap_taken), .trap_target_pc(trap_target_pc),
    .trap_new_priv(trap_new_priv), .status_o(status_o));

  tvd_core_model core (.sys_clk(sys_clk), .trap_valid(trap_valid), .trap_is_int(trap_is_int),
    .trap_cause(trap_cause), .trap_pc(trap_pc), .cur_priv(cur_priv));

  // Smaller configurations share the bus and the trap inputs
  tvd_trap_unit #(.SYS(tvd_pkg::TVD_SYS_MU)) dut_mu (.sys_clk(sys_clk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(dat_mu), .wb_ack_o(), .wb_err_o(),
    .trap_valid(trap_valid), .trap_is_int(trap_is_int), .trap_cause(trap_cause),
    .trap_pc(trap_pc), .cur_priv(cur_priv), .trap_taken(), .trap_target_pc(),
    .trap_new_priv(), .status_o());

  tvd_trap_unit #(.SYS(tvd_pkg::TVD_SYS_MUN)) dut_un (.sys_clk(sys_clk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(), .wb_ack_o(), .wb_err_o(),
    .trap_valid(trap_valid), .trap_is_int(trap_is_int), .trap_cause(trap_cause),
    .trap_pc(trap_pc), .cur_priv(cur_priv), .trap_taken(), .trap_target_pc(),
    .trap_new_priv(priv_un), .status_o());

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  // Hang guard: the whole run needs well under this many cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Wishbone classic master
  // ---------------------------------------------------------------
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                    output logic [31:0] q);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= wd;
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    rd_mu = dat_mu;
    `CHK(wb_err_o, 1'b0)
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // Expectation helpers
  // ---------------------------------------------------------------
  function automatic logic [1:0] exp_priv(logic ii, logic [4:0] c, logic [1:0] cur);
    logic dm, ds;
    dm = ii ? dv[1][c] : dv[0][c];
    ds = ii ? dv[3][c] : dv[2][c];
    if (cur == 2'h3 || !dm) return 2'h3;
    if (cur == 2'h0 && ds) return 2'h0;
    return 2'h1;
  endfunction

  function automatic logic [31:0] nxt_st(logic [31:0] s, logic [1:0] t, logic [1:0] cur);
    logic ie;
    // The enable of the mode that was running is the one saved
    ie = (cur == 2'h3) ? s[3] : (cur == 2'h0) ? s[0] : s[1];
    if (t == 2'h3) begin
      s[12:11] = cur;
      s[7] = ie;
      s[3] = 1'b0;
    end else if (t == 2'h1) begin
      s[8] = cur[0];
      s[5] = ie;
      s[1] = 1'b0;
    end else begin
      s[4] = ie;
      s[0] = 1'b0;
    end
    return s;
  endfunction

  initial begin
    logic [7:0]  offs [4];
    logic [31:0] msk [4];
    logic [1:0]  cur, tgt, un_e;
    logic [4:0]  c;
    logic [31:0] pc, tv;
    logic        ii;
    offs = '{`TVD_OFF_EDELEG, `TVD_OFF_IDELEG, `TVD_OFF_SEDELEG, `TVD_OFF_SIDELEG};
    msk = '{`TVD_EDELEG_MASK, `TVD_IDELEG_MASK, `TVD_SEDELEG_MASK, `TVD_SIDELEG_MASK};
    void'($urandom(44326));
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    wb(0, `TVD_OFF_TVEC, 0, rd);
    `CHK(rd, `TVD_TVEC_RESET)
    wb(0, `TVD_OFF_STATUS, 0, rd);
    `CHK(rd, `TVD_STATUS_RESET)
    `CHK(trap_new_priv, 2'h3)
    `CHK(trap_taken, 1'b0)
    for (int k = 0; k < 4; k++) begin
      wb(1, offs[k], 32'hFFFF_FFFF, rd);
      wb(0, offs[k], 0, rd);
      `CHK(rd, msk[k])
      `CHK(rd_mu, 32'h0000_0000)
      wb(1, offs[k], 32'h0000_0000, rd);
      wb(0, offs[k], 0, rd);
      `CHK(rd, 32'h0000_0000)
    end
    wb(1, 8'hFC, 32'hFFFF_FFFF, rd);
    wb(0, 8'hFC, 0, rd);
    `CHK(rd, 32'h0000_0000)
    wb(1, `TVD_OFF_TVEC, 32'h1234_5671, rd);
    wb(0, `TVD_OFF_TVEC, 0, rd);
    `CHK(rd, 32'h1234_5671)
    wb(1, `TVD_OFF_TVEC, 32'h0000_1003, rd);
    wb(0, `TVD_OFF_TVEC, 0, rd);
    `CHK(rd, 32'h0000_1001)
    st_e = `TVD_STATUS_RESET;
    for (int i = 0; i < 48; i++) begin
      if (i % 8 == 0) begin
        // Bases kept 16-byte aligned so vectored alignment never trims them
        for (int k = 0; k < 4; k++) begin
          dv[k] = $urandom() & msk[k];
          wb(1, offs[k], dv[k], rd);
          vec[k] = {$urandom() & 32'hFFFF_FFF0} | {31'h0, 1'((i == 0) | $urandom_range(1))};
        end
        wb(1, `TVD_OFF_TVEC, vec[3], rd);
        wb(1, `TVD_OFF_STVEC, vec[1], rd);
        wb(1, `TVD_OFF_UTVEC, vec[0], rd);
        st_e = ($urandom() & 32'h0000_000B) | `TVD_STATUS_RESET;
        wb(1, `TVD_OFF_STATUS, st_e, rd);
      end
      ii = (i == 0) ? 1'b1 : 1'($urandom_range(1));
      c = (i == 0) ? 5'h00 : 5'($urandom_range(ii ? 11 : 15));
      cur = (i == 0) ? 2'h3 : 2'($urandom_range(2));
      if (cur == 2'h2) cur = 2'h3;
      pc = $urandom();
      tgt = exp_priv(ii, c, cur);
      tv = vec[tgt];
      core.raise(ii, c, pc, cur);
      @(posedge sys_clk);
      `CHK(trap_taken, 1'b1)
      `CHK(trap_new_priv, tgt)
      `CHK(trap_target_pc, {tv[31:2], 2'h0} + ((tv[1:0] == 2'h1 && ii) ? {c, 2'h0} : 0))
      st_e = nxt_st(st_e, tgt, cur);
      `CHK(status_o, st_e)
      un_e = (cur == 2'h0 && (ii ? dv[1][c] : dv[0][c])) ? 2'h0 : 2'h3;
      if (cur != 2'h1) `CHK(priv_un, un_e)
      @(posedge sys_clk);
      `CHK(trap_taken, 1'b0)
      wb(0, tgt == 2'h3 ? `TVD_OFF_MCAUSE : tgt == 2'h1 ? `TVD_OFF_SCAUSE : `TVD_OFF_UCAUSE, 0, rd);
      `CHK(rd, {ii, 26'h0, c})
      wb(0, tgt == 2'h3 ? `TVD_OFF_MEPC : tgt == 2'h1 ? `TVD_OFF_SEPC : `TVD_OFF_UEPC, 0, rd);
      `CHK(rd, {pc[31:2], 2'h0})
      if (tgt == 2'h3) begin
        mc_e = {ii, 26'h0, c};
        me_e = {pc[31:2], 2'h0};
      end else begin
        wb(0, `TVD_OFF_MCAUSE, 0, rd);
        `CHK(rd, mc_e)
        wb(0, `TVD_OFF_MEPC, 0, rd);
        `CHK(rd, me_e)
      end
    end
    print_verdict();
  end
endmodule
